/* File: design/hpl_params.svh */
// constants for the host parallel port: control word fields, register map, timing
`ifndef HPL_PARAMS_SVH
`define HPL_PARAMS_SVH

`define HPL_WORD_W 16
`define HPL_CARD_W 12
`define HPL_SLOT_MSB 15
`define HPL_SLOT_LSB 12
`define HPL_SLOT_CTRL 4'hf
`define HPL_CW_UNIT_MSB 3
`define HPL_CW_UNIT_LSB 0
`define HPL_CW_TME_BIT 4
`define HPL_CW_SYE_BIT 5
`define HPL_CW_IEN_BIT 6
`define HPL_CW_ISL_BIT 7
`define HPL_CW_DTE_BIT 8
`define HPL_REQ_BIT 15
`define HPL_RET_OE_MASK 16'h8fff

`define HPL_ADDR_MODE 12'h000
`define HPL_ADDR_STATUS 12'h004
`define HPL_ADDR_TIMING 12'h008
`define HPL_ADDR_LASTWORD 12'h00c
`define HPL_DEC_W 12

`define HPL_CLK_PERIOD_NS 20
`define HPL_BUSY_TIME_NS 2000
`define HPL_BUSY_CYC ((`HPL_BUSY_TIME_NS + `HPL_CLK_PERIOD_NS - 1) / `HPL_CLK_PERIOD_NS)
`define HPL_TIMING_W 16

`endif

/* File: design/hpl_pkg.sv */
// types shared by the host parallel port
package hpl_pkg;

	// latched mode signals, forwarded to the extender units
	typedef struct packed {
		logic [3:0] unit;
		logic third_mode_control_signal;
		logic timing_mode_signal;
		logic interrupt_enable_mode;
		logic input_select_mode;
		logic system_enable_signal;
	} hpl_mode_s;

	// action strobes to the card cage
	typedef struct packed {
		logic store;
		logic activate;
		logic deactivate;
	} hpl_cmd_s;

	// flag states, gray along ready -> busy -> waiting
	typedef enum logic [1:0] {
		HPL_READY = 2'b00,
		HPL_OUT_BUSY = 2'b01,
		HPL_IN_WAIT = 2'b11
	} hpl_flag_e;

endpackage

/* File: design/hpl_host_port.sv */
// host-facing parallel port: word capture, mode storage, flag, return lines, ahb-lite status
`timescale 1ns/10ps
`include "hpl_params.svh"

module hpl_host_port
	import hpl_pkg::*;
#(
	parameter int TIMING_W = `HPL_TIMING_W
)
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// ahb-lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	// host connector pins
	input wire logic [15:0] i_host_data_n,
	input wire logic i_host_gate,
	input wire logic i_interlock_closed,
	output logic o_flag,
	output logic [15:0] o_return_n,
	output logic [15:0] o_return_oe,
	output logic o_test_third_mode,
	output logic o_test_timing_mode,
	output logic o_test_interrupt_enable,
	// front panel
	input wire logic i_local_mode,
	input wire logic [15:0] i_panel_switch,
	// card cage and extender chain
	input wire logic [11:0] i_card_data,
	input wire logic i_card_request,
	input wire logic i_card_done,
	output hpl_mode_s o_mode,
	output logic [15:0] o_card_word,
	output hpl_cmd_s o_card_cmd,
	output logic o_input_request,
	output logic o_output_enable
);

	// refuse widths the timing counter cannot serve
	generate
		if (TIMING_W < 8 || TIMING_W > 32)
		begin : g_bad_width
			$error("hpl_host_port: TIMING_W must lie between 8 and 32");
		end
	endgenerate

	localparam logic [TIMING_W-1:0] BUSY_CYC = TIMING_W'(`HPL_BUSY_CYC);

	// two-flop synchronisers for every pin-side input
	logic [15:0] data_s1_q;
	logic [15:0] data_s2_q;
	logic gate_s1_q;
	logic gate_s2_q;
	logic gate_s3_q;
	logic [3:0] misc_s1_q;
	logic [3:0] misc_s2_q;
	logic [15:0] panel_s1_q;
	logic [15:0] panel_s2_q;
	logic [11:0] card_s1_q;
	logic [11:0] card_s2_q;

	// only the second stage of each synchroniser is read below, except the gate, whose third stage gate_s3_q is also read
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			data_s1_q <= 16'hffff;
			data_s2_q <= 16'hffff;
			gate_s1_q <= 1'b1;
			gate_s2_q <= 1'b1;
			gate_s3_q <= 1'b1;
			misc_s1_q <= 4'h0;
			misc_s2_q <= 4'h0;
			panel_s1_q <= 16'h0000;
			panel_s2_q <= 16'h0000;
			card_s1_q <= 12'h000;
			card_s2_q <= 12'h000;
		end
		else
		begin
			data_s1_q <= i_host_data_n;
			data_s2_q <= data_s1_q;
			gate_s1_q <= i_host_gate;
			gate_s2_q <= gate_s1_q;
			gate_s3_q <= gate_s2_q;
			misc_s1_q <= {i_interlock_closed, i_local_mode, i_card_request, i_card_done};
			misc_s2_q <= misc_s1_q;
			panel_s1_q <= i_panel_switch;
			panel_s2_q <= panel_s1_q;
			card_s1_q <= i_card_data;
			card_s2_q <= card_s1_q;
		end
	end

	logic interlock_ok;
	logic local_mode;
	logic card_req;
	logic card_done;
	assign interlock_ok = misc_s2_q[3];
	assign local_mode = misc_s2_q[2];
	assign card_req = misc_s2_q[1];
	assign card_done = misc_s2_q[0];

	// word decode: positive logic, slot field 1111 marks a control word
	logic [15:0] word;
	logic gate_fall;
	logic is_ctrl;
	assign word = ~data_s2_q;
	// the extra stage makes the edge visible for exactly one cycle
	assign gate_fall = gate_s3_q & ~gate_s2_q;
	assign is_ctrl = (word[`HPL_SLOT_MSB:`HPL_SLOT_LSB] == `HPL_SLOT_CTRL);

	// mode storage, written only by a gated control word
	hpl_mode_s mode_q;
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			mode_q <= '0;
		end
		else if (gate_fall && is_ctrl)
		begin
			mode_q.unit <= word[`HPL_CW_UNIT_MSB:`HPL_CW_UNIT_LSB];
			mode_q.third_mode_control_signal <= word[`HPL_CW_DTE_BIT];
			mode_q.timing_mode_signal <= word[`HPL_CW_TME_BIT];
			mode_q.interrupt_enable_mode <= word[`HPL_CW_IEN_BIT];
			mode_q.input_select_mode <= word[`HPL_CW_ISL_BIT];
			mode_q.system_enable_signal <= word[`HPL_CW_SYE_BIT];
		end
	end

	// output cards may only store while enabled and the plug loop is closed
	logic out_en;
	assign out_en = mode_q.system_enable_signal & interlock_ok;

	// one-cycle action strobes derived from a gated non-control word
	logic do_store;
	logic do_activate;
	logic do_deactivate;
	assign do_store = gate_fall & ~is_ctrl & ~mode_q.input_select_mode & out_en;
	assign do_activate = gate_fall & ~is_ctrl & mode_q.input_select_mode
		& mode_q.interrupt_enable_mode;
	assign do_deactivate = gate_fall & ~is_ctrl & mode_q.input_select_mode
		& ~mode_q.interrupt_enable_mode;

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_card_cmd <= '0;
			o_card_word <= 16'h0000;
		end
		else
		begin
			o_card_cmd.store <= do_store;
			o_card_cmd.activate <= do_activate;
			o_card_cmd.deactivate <= do_deactivate;
			// address and data go down the chain continuously; the strobe qualifies them
			o_card_word <= word;
		end
	end

	// software-set busy time for timing-style flags
	logic [TIMING_W-1:0] busy_len_q;
	logic [TIMING_W-1:0] busy_cnt_q;
	hpl_flag_e flag_q;

	// flag state: ready, busy storing, or waiting on an input device
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			flag_q <= HPL_READY;
		end
		else
		begin
			case (flag_q)
				HPL_READY:
				begin
					if (do_store)
					begin
						flag_q <= HPL_OUT_BUSY;
					end
					else if (do_activate)
					begin
						flag_q <= HPL_IN_WAIT;
					end
				end
				HPL_OUT_BUSY:
				begin
					// timing style runs a fixed time, handshake waits for the card
					if (mode_q.timing_mode_signal ? (busy_cnt_q == '0) : card_done)
					begin
						flag_q <= HPL_READY;
					end
				end
				HPL_IN_WAIT:
				begin
					if (card_req)
					begin
						flag_q <= HPL_READY;
					end
					else if (do_deactivate)
					begin
						flag_q <= HPL_READY;
					end
				end
				default:
				begin
					flag_q <= HPL_READY;
				end
			endcase
		end
	end

	// busy time counter, loaded when a store begins
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			busy_cnt_q <= '0;
		end
		else if (do_store && flag_q == HPL_READY)
		begin
			busy_cnt_q <= busy_len_q - TIMING_W'(1);
		end
		else if (busy_cnt_q != '0)
		begin
			busy_cnt_q <= busy_cnt_q - TIMING_W'(1);
		end
	end

	// return line source selection
	logic [15:0] ret;
	always_comb
	begin
		ret = 16'h0000;
		if (mode_q.input_select_mode)
		begin
			ret[11:0] = card_s2_q;
			if (local_mode)
			begin
				ret[`HPL_REQ_BIT] = panel_s2_q[`HPL_REQ_BIT];
			end
			else
			begin
				ret[`HPL_REQ_BIT] = word[`HPL_REQ_BIT] | card_req;
			end
		end
		else if (local_mode)
		begin
			ret[11:0] = panel_s2_q[11:0];
			ret[`HPL_REQ_BIT] = panel_s2_q[`HPL_REQ_BIT];
		end
		else
		begin
			ret[11:0] = word[11:0];
			ret[`HPL_REQ_BIT] = word[`HPL_REQ_BIT];
		end
	end

	// pin outputs, all registered; return lines are ground-true like the inputs
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_flag <= 1'b0;
			o_return_n <= 16'hffff;
			o_return_oe <= 16'h0000;
			o_mode <= '0;
			o_test_third_mode <= 1'b0;
			o_test_timing_mode <= 1'b0;
			o_test_interrupt_enable <= 1'b0;
			o_input_request <= 1'b0;
			o_output_enable <= 1'b0;
		end
		else
		begin
			o_flag <= (flag_q == HPL_READY);
			o_return_n <= ~ret;
			// bits 12 to 14 stay undriven so the host pull-ups own them
			o_return_oe <= `HPL_RET_OE_MASK;
			o_mode <= mode_q;
			o_test_third_mode <= mode_q.third_mode_control_signal;
			o_test_timing_mode <= mode_q.timing_mode_signal;
			o_test_interrupt_enable <= mode_q.interrupt_enable_mode;
			o_input_request <= card_req;
			o_output_enable <= out_en;
		end
	end

	// last host word seen with a gate, for software inspection
	logic [15:0] last_word_q;
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			last_word_q <= 16'h0000;
		end
		else if (gate_fall)
		begin
			last_word_q <= word;
		end
	end

	// ahb-lite address phase capture; zero wait states
	logic wr_pend_q;
	logic [`HPL_DEC_W-1:0] wr_addr_q;
	logic addr_phase;
	assign addr_phase = i_hsel & i_htrans[1] & i_hready;

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
		end
		else
		begin
			wr_pend_q <= addr_phase & i_hwrite;
			wr_addr_q <= i_haddr[`HPL_DEC_W-1:0];
		end
	end

	// timing register write in the data phase; zero length is refused as meaningless
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			busy_len_q <= BUSY_CYC;
		end
		else if (wr_pend_q && wr_addr_q == `HPL_ADDR_TIMING && i_hwdata[TIMING_W-1:0] != '0)
		begin
			busy_len_q <= i_hwdata[TIMING_W-1:0];
		end
	end

	// read data decode, presented in the data phase
	logic [31:0] rd_d;
	always_comb
	begin
		rd_d = 32'h0000_0000;
		if (i_haddr[`HPL_DEC_W-1:0] == `HPL_ADDR_MODE)
		begin
			rd_d[8:0] = mode_q;
		end
		else if (i_haddr[`HPL_DEC_W-1:0] == `HPL_ADDR_STATUS)
		begin
			rd_d[7:0] = {2'b00, flag_q, interlock_ok, local_mode, card_req, out_en};
		end
		else if (i_haddr[`HPL_DEC_W-1:0] == `HPL_ADDR_TIMING)
		begin
			rd_d[TIMING_W-1:0] = busy_len_q;
		end
		else if (i_haddr[`HPL_DEC_W-1:0] == `HPL_ADDR_LASTWORD)
		begin
			rd_d[15:0] = last_word_q;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_hrdata <= 32'h0000_0000;
			o_hreadyout <= 1'b0;
			o_hresp <= 1'b0;
		end
		else
		begin
			if (addr_phase && !i_hwrite)
			begin
				o_hrdata <= rd_d;
			end
			o_hreadyout <= 1'b1; // never stalls
			o_hresp <= 1'b0; // always okay
		end
	end

endmodule

/* File: verif/hpl_host_port_assertions.sv */
// pin-level checker for the host parallel port
`timescale 1ns/10ps
module hpl_host_port_checker
	import hpl_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [15:0] i_host_data_n,
	input wire logic i_host_gate,
	input wire logic i_interlock_closed,
	input wire logic i_local_mode,
	input wire logic [15:0] i_panel_switch,
	input wire logic [11:0] i_card_data,
	input wire logic i_card_request,
	input wire logic o_flag,
	input wire logic [15:0] o_return_n,
	input wire logic [15:0] o_return_oe,
	input wire hpl_mode_s o_mode,
	input wire hpl_cmd_s o_card_cmd,
	input wire logic o_output_enable
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	chk_upper_undriven: assert property (o_return_oe[14:12] == 3'h0)
		else $error("return bits 12-14 enabled");
	chk_lock_disable: assert property (!i_interlock_closed [*4] |-> !o_output_enable)
		else $error("outputs enabled with interlock open");
	// the flag register follows the strobe by one clock, so busy shows on the next cycle
	chk_store_busy: assert property (o_card_cmd.store |=> !o_flag)
		else $error("flag ready during store");
	// a gated non-control word must reach the card cage in a few cycles
	chk_gate_store: assert property ($fell(i_host_gate) && i_host_data_n[15:12] != 4'h0 && o_output_enable
		&& !o_mode.input_select_mode && !i_local_mode |-> ##[2:7] o_card_cmd.store)
		else $error("gate gave no store");
	// settled inputs give settled return lines, allowing for the sync stages
	chk_echo_host: assert property ((!i_local_mode && !o_mode.input_select_mode && $stable(i_host_data_n)) [*5]
		|-> (o_return_n & 16'h8fff) == (i_host_data_n & 16'h8fff)) else $error("echo wrong");
	chk_isl_data: assert property ((o_mode.input_select_mode && $stable(i_card_data)) [*5]
		|-> o_return_n[11:0] == ~i_card_data) else $error("card data wrong");
	chk_bit15_req: assert property ((!i_local_mode && o_mode.input_select_mode
		&& $stable({i_card_request, i_host_data_n[15]})) [*5]
		|-> o_return_n[15] == (i_host_data_n[15] & !i_card_request)) else $error("bit 15 wrong");
	chk_panel_echo: assert property ((i_local_mode && !o_mode.input_select_mode && $stable(i_panel_switch)) [*5]
		|-> (o_return_n & 16'h8fff) == (~i_panel_switch & 16'h8fff)) else $error("panel echo wrong");
endmodule

bind hpl_host_port hpl_host_port_checker chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
	.i_host_data_n(i_host_data_n), .i_host_gate(i_host_gate), .i_interlock_closed(i_interlock_closed),
	.i_local_mode(i_local_mode), .i_panel_switch(i_panel_switch), .i_card_data(i_card_data),
	.i_card_request(i_card_request), .o_flag(o_flag), .o_return_n(o_return_n), .o_return_oe(o_return_oe),
	.o_mode(o_mode), .o_card_cmd(o_card_cmd), .o_output_enable(o_output_enable));

/* File: verif/hpl_host_model.sv */
// host computer side: sends one word with a gate, then waits for ready
`timescale 1ns/10ps
module hpl_host_model
(
	input wire logic i_clk,
	input wire logic i_flag,
	output logic [15:0] o_host_data_n,
	output logic o_host_gate
);
	// idle host: gate high, data lines driven
	initial
	begin
		o_host_data_n = 16'hffff;
		o_host_gate = 1'b1;
	end

	// data settles four cycles before the gate falls and stays after it
	task automatic send(input logic [15:0] x, input bit wt, output bit ok);
		int k;
		o_host_data_n <= ~x;
		repeat (4) @(posedge i_clk);
		o_host_gate <= 1'b0;
		repeat (2) @(posedge i_clk);
		o_host_gate <= 1'b1;
		repeat (4) @(posedge i_clk);
		for (k = 0; wt && i_flag !== 1'b1 && k < 5000; k++) @(posedge i_clk);
		ok = (k < 5000);
	endtask
endmodule

/* File: verif/hpl_host_port_test.sv */
// self-checking bench for the host parallel port
`timescale 1ns/10ps
`include "hpl_params.svh"
module hpl_host_port_test
	import hpl_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0, lock = 1'b1, local_m = 1'b0, req = 1'b0, done = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	logic [11:0] cdata = 12'h0;
	logic [15:0] panel = 16'h0, hdata_n, ret_n, ret_oe, cword, w;
	logic hrdy, hresp, gate, flag, t_dte, t_tme, t_ien, ireq, oen;
	hpl_mode_s mode;
	hpl_cmd_s cmd;
	int seed = 32'h42a51c05;
	int bad_count = 0, checked = 0, n_st = 0, n_act = 0, n_de = 0, n, k;

	// 50 MHz clock
	always #10 i_clk = ~i_clk;
	// count command pulses seen by the card cage
	always @(posedge i_clk)
	begin
		n_st <= n_st + cmd.store;
		n_act <= n_act + cmd.activate;
		n_de <= n_de + cmd.deactivate;
	end

	hpl_host_port dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy),
		.o_hresp(hresp), .o_hrdata(hrdata), .i_host_data_n(hdata_n), .i_host_gate(gate), .i_interlock_closed(lock),
		.o_flag(flag), .o_return_n(ret_n), .o_return_oe(ret_oe), .o_test_third_mode(t_dte),
		.o_test_timing_mode(t_tme), .o_test_interrupt_enable(t_ien), .i_local_mode(local_m),
		.i_panel_switch(panel), .i_card_data(cdata), .i_card_request(req), .i_card_done(done), .o_mode(mode),
		.o_card_word(cword), .o_card_cmd(cmd), .o_input_request(ireq), .o_output_enable(oen));
	hpl_host_model host (.i_clk(i_clk), .i_flag(flag), .o_host_data_n(hdata_n), .o_host_gate(gate));

	// verdict and end of run
	task automatic report_and_stop();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic hang(input bit stuck);
		if (stuck)
		begin
			bad_count++;
			report_and_stop();
		end
	endtask

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	// single word transfer; each phase is held until hready is sampled high
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int c;
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		c = 0;
		do @(posedge i_clk); while (hrdy !== 1'b1 && c++ < 50);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge i_clk); while (hrdy !== 1'b1 && c++ < 100);
		hang(c >= 100);
		r = hrdata;
	endtask

	task automatic rd_cmp(input string nm, input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		cmp(nm, e, r);
		cmp("resp", 0, hresp);
	endtask

	task automatic put(input logic [15:0] x, input bit wt);
		bit ok;
		host.send(x, wt, ok);
		hang(!ok);
	endtask

	// mode storage as the control word fields lay it out
	function automatic logic [31:0] mode_of(input logic [15:0] x);
		return {23'h0, x[3:0], x[8], x[4], x[6], x[7], x[5]};
	endfunction

	initial
	begin
		repeat (4) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		repeat (2) @(posedge i_clk);
		cmp("flag", 1, flag);
		rd_cmp("timing", `HPL_ADDR_TIMING, `HPL_BUSY_CYC);
		rd_cmp("unmapped", 32'h40, 0);
		bus(1'b1, `HPL_ADDR_TIMING, 4);
		rd_cmp("timing", `HPL_ADDR_TIMING, 4);
		// a zero busy time is refused and the old value kept
		bus(1'b1, `HPL_ADDR_TIMING, 0);
		rd_cmp("timing", `HPL_ADDR_TIMING, 4);
		// timing style, system enabled, then corner and random data words
		w = 16'hf033;
		put(w, 1);
		rd_cmp("mode", `HPL_ADDR_MODE, mode_of(w));
		cmp("mode", mode_of(w), mode);
		cmp("test", {w[8], w[4], w[6]}, {t_dte, t_tme, t_ien});
		cmp("oen", 1, oen);
		for (k = 0; k < 10; k++)
		begin
			w = (k == 0) ? 16'hefff : (k == 1) ? 16'h0000 : 16'($random(seed));
			w[15:12] = w[15:12] % 4'hf;
			n = n_st;
			put(w, 1);
			cmp("store", n + 1, n_st);
			cmp("word", w, cword);
			cmp("echo", ~w & 16'h8fff, ret_n & 16'h8fff);
		end
		rd_cmp("last", `HPL_ADDR_LASTWORD, w);
		// handshake style holds busy until the card is done
		put(16'hf023, 1);
		put(16'h0123, 0);
		repeat (20) @(posedge i_clk);
		cmp("busy", 0, flag);
		done <= 1'b1;
		repeat (5) @(posedge i_clk);
		cmp("ready", 1, flag);
		done <= 1'b0;
		// open interlock, then system enable off
		lock <= 1'b0;
		repeat (5) @(posedge i_clk);
		cmp("oen", 0, oen);
		n = n_st;
		put(16'h0456, 1);
		cmp("store", n, n_st);
		lock <= 1'b1;
		put(16'hf013, 1);
		cmp("oen", 0, oen);
		local_m <= 1'b1;
		panel <= 16'($random(seed));
		repeat (5) @(posedge i_clk);
		cmp("panel", ~panel & 16'h8fff, ret_n & 16'h8fff);
		local_m <= 1'b0;
		// input select: card data, activation waits for the request
		cdata <= 12'($random(seed));
		put(16'hf0f3, 1);
		cmp("card", {20'h0, ~cdata}, ret_n[11:0]);
		n = n_act;
		put(16'h2000, 0);
		cmp("act", n + 1, n_act);
		cmp("wait", 0, flag);
		req <= 1'b1;
		for (n = 0; flag !== 1'b1 && n < 20; n++) @(posedge i_clk);
		hang(n >= 20);
		cmp("ready", 1, flag);
		cmp("ireq", 1, ireq);
		cmp("b15", 0, ret_n[15]);
		put(16'hf0b3, 1);
		n = n_de;
		put(16'h2000, 1);
		cmp("deact", n + 1, n_de);
		local_m <= 1'b1;
		repeat (5) @(posedge i_clk);
		cmp("local", {~panel[15], 3'h0, ~cdata}, ret_n & 16'h8fff);
		cmp("oe", 16'h8fff, ret_oe);
		// status: flag ready, interlock closed, local, request up, outputs enabled
		rd_cmp("status", `HPL_ADDR_STATUS, 32'h0000_000f);
		report_and_stop();
	end
endmodule
